// >>> hdl/ebalu_consts.vh
`ifndef EBALU_CONSTS_VH
`define EBALU_CONSTS_VH
// Operation codes from the decoder.
`define EBALU_OP_W        5
`define EBALU_OP_NOP      5'h00
`define EBALU_OP_ADD      5'h01
`define EBALU_OP_ADC      5'h02
`define EBALU_OP_WADD     5'h03
`define EBALU_OP_SUB      5'h04
`define EBALU_OP_SUBK     5'h05
`define EBALU_OP_SUBB     5'h06
`define EBALU_OP_SUBBK    5'h07
`define EBALU_OP_WSUB     5'h08
`define EBALU_OP_AND      5'h09
`define EBALU_OP_ANDK     5'h0a
`define EBALU_OP_OR       5'h0b
`define EBALU_OP_ORK      5'h0c
`define EBALU_OP_XOR      5'h0d
`define EBALU_OP_COM      5'h0e
`define EBALU_OP_NEGATE   5'h0f
`define EBALU_OP_IOSET    5'h10
`define EBALU_OP_IOCLR    5'h11
`define EBALU_OP_SKIPHI   5'h12
`define EBALU_OP_SKIPLO   5'h13
// Status flag positions.
`define EBALU_F_C         0
`define EBALU_F_Z         1
`define EBALU_F_N         2
`define EBALU_F_V         3
`define EBALU_F_S         4
`define EBALU_F_H         5
`define EBALU_FLAGS_W     6
`define EBALU_FLAGS_RST   6'h00
// Low io space reachable by bit instructions.
`define EBALU_IO_ADDR_W   6
`define EBALU_IO_BIT_MAX  6'h1f
`define EBALU_IO_SPACE    32
`define EBALU_IO_IDX_MSB  4
// Word state machine.
`define EBALU_ST_IDLE     1'b0
`define EBALU_ST_HIGH     1'b1
`define EBALU_BYTE_ZERO   8'h00
`define EBALU_BYTE_ONES   8'hff
`define EBALU_BYTE_MIN    8'h80
`define EBALU_MSB         7
`define EBALU_HNIB        3
`endif

// >>> hdl/ebalu_core.v
// How it works
// - Add and add-with-carry store the byte sum and set Z,C,N,V,H in one clock.
// - Word add of a constant to a register pair takes two clocks, sets Z,C,N,V,S.
// - Subtract register or constant stores difference, sets Z,C,N,V,H in one clock.
// - Borrow subtract also removes the carry flag, sets Z,C,N,V,H in one clock.
// - Word subtract of a constant writes both halves over two clocks, sets Z,C,N,V,S.
// - Conjunction with register or constant writes result, changes only Z,N,V.
// - Disjunction and exclusive disjunction write result, change only Z,N,V.
// - Bit set and clear are accepted only for io addresses 0x00 to 0x1f.
// - Skip tests check one chosen bit of a low io register.
// - Bit set and clear change only the addressed bit.
// - Some status flags clear when a one is written, a zero leaves them, unless a bit set or clear comes in the same clock.
`timescale 1ns/10ps
`include "ebalu_consts.vh"
module ebalu_core
(
  input  wire                        clk_i,
  input  wire                        rst_n_i,
  input  wire                        start_i,
  input  wire [`EBALU_OP_W-1:0]      op_i,
  input  wire [7:0]                  rd_i,
  input  wire [7:0]                  rr_i,
  input  wire [7:0]                  rd_high_i,
  input  wire [7:0]                  imm_i,
  input  wire [`EBALU_IO_ADDR_W-1:0] io_addr_i,
  input  wire [2:0]                  io_bit_i,
  input  wire                        io_w1c_i,
  input  wire [7:0]                  io_w1c_mask_i,
  input  wire [`EBALU_IO_ADDR_W-1:0] io_rd_addr_i,
  output reg  [7:0]                  result_o,
  output reg                         wr_low_o,
  output reg                         wr_high_o,
  output reg  [`EBALU_FLAGS_W-1:0]   flags_o,
  output reg                         busy_o,
  output reg                         skip_o,
  output reg                         skip_valid_o,
  output reg                         io_reject_o,
  output wire [7:0]                  io_rd_data_o
);
  reg                       state_q;
  reg                       state_d;
  reg [7:0]                 word_hi_q;
  reg                       word_sub_q;
  reg                       word_c_q;
  reg                       word_zl_q;
  reg [7:0]                 res_d;
  reg [`EBALU_FLAGS_W-1:0]  flg_d;
  reg                       wl_d;
  reg                       wh_d;
  reg                       skip_d;
  reg                       skv_d;
  reg                       rej_d;
  reg [7:0]                 b;
  reg                       cin;
  reg                       is_sub;
  reg                       arith;
  reg                       logic_op;
  reg [7:0]                 lres;
  reg [8:0]                 sum;
  reg                       io_set;
  reg                       io_clr;
  reg                       io_ok;
  reg [7:0]                 wres;
  reg [8:0]                 wsum;
  reg                       wv;
  wire                      carry_q = flags_o[`EBALU_F_C];
  wire                      idle    = (state_q == `EBALU_ST_IDLE);
  wire [7:0]                io_byte;

  // Skip tests sample the io byte selected by io_rd_addr_i in the previous cycle.
  ebalu_io_bits u_io
  (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .set_i      (io_set),
    .clr_i      (io_clr),
    .w1c_i      (io_w1c_i),
    .addr_i     (io_addr_i),
    .bit_i      (io_bit_i),
    .w1c_mask_i (io_w1c_mask_i),
    .rd_addr_i  (io_rd_addr_i),
    .rd_data_o  (io_byte)
  );
  assign io_rd_data_o = io_byte;

  always @*
  begin
    res_d    = result_o;
    flg_d    = flags_o;
    wl_d     = 1'b0;
    wh_d     = 1'b0;
    skip_d   = 1'b0;
    skv_d    = 1'b0;
    rej_d    = 1'b0;
    state_d  = state_q;
    b        = rr_i;
    cin      = 1'b0;
    is_sub   = 1'b0;
    arith    = 1'b0;
    logic_op = 1'b0;
    lres     = `EBALU_BYTE_ZERO;
    sum      = 9'h000;
    io_ok    = (io_addr_i <= `EBALU_IO_BIT_MAX);
    io_set   = 1'b0;
    io_clr   = 1'b0;
    wres     = `EBALU_BYTE_ZERO;
    wsum     = 9'h000;
    wv       = 1'b0;
    if (!idle)
    begin
      // Second clock of a word operation: carry into the high byte.
      if (word_sub_q)
        wsum = {1'b0, word_hi_q} - {8'h00, word_c_q};
      else
        wsum = {1'b0, word_hi_q} + {8'h00, word_c_q};
      wres = wsum[7:0];
      wv   = word_sub_q ? (word_hi_q[`EBALU_MSB] & ~wres[`EBALU_MSB])
                        : (~word_hi_q[`EBALU_MSB] & wres[`EBALU_MSB]);
      res_d = wres;
      wh_d  = 1'b1;
      flg_d[`EBALU_F_C] = word_sub_q ? (wres[`EBALU_MSB] & ~word_hi_q[`EBALU_MSB])
                                     : (~wres[`EBALU_MSB] & word_hi_q[`EBALU_MSB]);
      flg_d[`EBALU_F_Z] = word_zl_q & (wres == `EBALU_BYTE_ZERO);
      flg_d[`EBALU_F_N] = wres[`EBALU_MSB];
      flg_d[`EBALU_F_V] = wv;
      flg_d[`EBALU_F_S] = wres[`EBALU_MSB] ^ wv;
      state_d = `EBALU_ST_IDLE;
    end
    else if (start_i)
    begin
      case (op_i)
        `EBALU_OP_ADD:  arith = 1'b1;
        `EBALU_OP_ADC:
        begin
          arith = 1'b1;
          cin   = carry_q;
        end
        `EBALU_OP_SUB:
        begin
          arith  = 1'b1;
          is_sub = 1'b1;
        end
        `EBALU_OP_SUBK:
        begin
          arith  = 1'b1;
          is_sub = 1'b1;
          b      = imm_i;
        end
        `EBALU_OP_SUBB:
        begin
          arith  = 1'b1;
          is_sub = 1'b1;
          cin    = carry_q;
        end
        `EBALU_OP_SUBBK:
        begin
          arith  = 1'b1;
          is_sub = 1'b1;
          b      = imm_i;
          cin    = carry_q;
        end
        `EBALU_OP_NEGATE:
        begin
          // Negation is zero minus the operand, so it shares the subtractor.
          arith  = 1'b1;
          is_sub = 1'b1;
        end
        `EBALU_OP_WADD, `EBALU_OP_WSUB:
        begin
          if (op_i == `EBALU_OP_WSUB)
            sum = {1'b0, rd_i} - {1'b0, imm_i};
          else
            sum = {1'b0, rd_i} + {1'b0, imm_i};
          res_d   = sum[7:0];
          wl_d    = 1'b1;
          state_d = `EBALU_ST_HIGH;
        end
        `EBALU_OP_AND:
        begin
          logic_op = 1'b1;
          lres     = rd_i & rr_i;
        end
        `EBALU_OP_ANDK:
        begin
          logic_op = 1'b1;
          lres     = rd_i & imm_i;
        end
        `EBALU_OP_OR:
        begin
          logic_op = 1'b1;
          lres     = rd_i | rr_i;
        end
        `EBALU_OP_ORK:
        begin
          logic_op = 1'b1;
          lres     = rd_i | imm_i;
        end
        `EBALU_OP_XOR:
        begin
          logic_op = 1'b1;
          lres     = rd_i ^ rr_i;
        end
        `EBALU_OP_COM:
        begin
          lres  = `EBALU_BYTE_ONES - rd_i;
          res_d = lres;
          wl_d  = 1'b1;
          flg_d[`EBALU_F_Z] = (lres == `EBALU_BYTE_ZERO);
          flg_d[`EBALU_F_N] = lres[`EBALU_MSB];
          flg_d[`EBALU_F_V] = 1'b0;
          flg_d[`EBALU_F_C] = 1'b1;
          flg_d[`EBALU_F_S] = lres[`EBALU_MSB];
        end
        `EBALU_OP_IOSET:
        begin
          io_set = io_ok;
          rej_d  = ~io_ok;
        end
        `EBALU_OP_IOCLR:
        begin
          io_clr = io_ok;
          rej_d  = ~io_ok;
        end
        `EBALU_OP_SKIPHI:
        begin
          skv_d  = io_ok;
          rej_d  = ~io_ok;
          skip_d = io_ok & io_byte[io_bit_i];
        end
        `EBALU_OP_SKIPLO:
        begin
          skv_d  = io_ok;
          rej_d  = ~io_ok;
          skip_d = io_ok & ~io_byte[io_bit_i];
        end
        default: ;
      endcase
      if (arith)
      begin
        if (op_i == `EBALU_OP_NEGATE)
          sum = {1'b0, `EBALU_BYTE_ZERO} - {1'b0, rd_i};
        else if (is_sub)
          sum = {1'b0, rd_i} - {1'b0, b} - {8'h00, cin};
        else
          sum = {1'b0, rd_i} + {1'b0, b} + {8'h00, cin};
        res_d = sum[7:0];
        wl_d  = 1'b1;
        flg_d[`EBALU_F_C] = sum[8];
        flg_d[`EBALU_F_Z] = (sum[7:0] == `EBALU_BYTE_ZERO);
        flg_d[`EBALU_F_N] = sum[`EBALU_MSB];
        if (op_i == `EBALU_OP_NEGATE)
        begin
          flg_d[`EBALU_F_V] = (sum[7:0] == `EBALU_BYTE_MIN);
          flg_d[`EBALU_F_H] = sum[`EBALU_HNIB] | rd_i[`EBALU_HNIB];
        end
        else if (is_sub)
        begin
          flg_d[`EBALU_F_V] = (rd_i[`EBALU_MSB] & ~b[`EBALU_MSB] & ~sum[`EBALU_MSB]) |
                              (~rd_i[`EBALU_MSB] & b[`EBALU_MSB] & sum[`EBALU_MSB]);
          flg_d[`EBALU_F_H] = (~rd_i[`EBALU_HNIB] & b[`EBALU_HNIB]) |
                              (b[`EBALU_HNIB] & sum[`EBALU_HNIB]) |
                              (sum[`EBALU_HNIB] & ~rd_i[`EBALU_HNIB]);
        end
        else
        begin
          flg_d[`EBALU_F_V] = (rd_i[`EBALU_MSB] & b[`EBALU_MSB] & ~sum[`EBALU_MSB]) |
                              (~rd_i[`EBALU_MSB] & ~b[`EBALU_MSB] & sum[`EBALU_MSB]);
          flg_d[`EBALU_F_H] = (rd_i[`EBALU_HNIB] & b[`EBALU_HNIB]) |
                              (b[`EBALU_HNIB] & ~sum[`EBALU_HNIB]) |
                              (~sum[`EBALU_HNIB] & rd_i[`EBALU_HNIB]);
        end
        flg_d[`EBALU_F_S] = flg_d[`EBALU_F_N] ^ flg_d[`EBALU_F_V];
      end
      if (logic_op)
      begin
        // Logic operations touch only Z, N and V; S keeps its earlier value.
        res_d = lres;
        wl_d  = 1'b1;
        flg_d[`EBALU_F_Z] = (lres == `EBALU_BYTE_ZERO);
        flg_d[`EBALU_F_N] = lres[`EBALU_MSB];
        flg_d[`EBALU_F_V] = 1'b0;
      end
    end
  end

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q      <= `EBALU_ST_IDLE;
      word_hi_q    <= `EBALU_BYTE_ZERO;
      word_sub_q   <= 1'b0;
      word_c_q     <= 1'b0;
      word_zl_q    <= 1'b0;
      result_o     <= `EBALU_BYTE_ZERO;
      wr_low_o     <= 1'b0;
      wr_high_o    <= 1'b0;
      flags_o      <= `EBALU_FLAGS_RST;
      busy_o       <= 1'b0;
      skip_o       <= 1'b0;
      skip_valid_o <= 1'b0;
      io_reject_o  <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      result_o     <= res_d;
      wr_low_o     <= wl_d;
      wr_high_o    <= wh_d;
      flags_o      <= flg_d;
      busy_o       <= (state_d == `EBALU_ST_HIGH);
      skip_o       <= skip_d;
      skip_valid_o <= skv_d;
      io_reject_o  <= rej_d;
      if (idle && start_i && (op_i == `EBALU_OP_WADD || op_i == `EBALU_OP_WSUB))
      begin
        word_hi_q  <= rd_high_i;
        word_sub_q <= (op_i == `EBALU_OP_WSUB);
        word_c_q   <= sum[8];
        word_zl_q  <= (sum[7:0] == `EBALU_BYTE_ZERO);
      end
    end
  end
endmodule // ebalu_core

// >>> hdl/ebalu_io_bits.v
`timescale 1ns/10ps
`include "ebalu_consts.vh"
// Low io space held bit by bit, so a bit write touches nothing else.
module ebalu_io_bits
(
  input  wire                        clk_i,
  input  wire                        rst_n_i,
  input  wire                        set_i,
  input  wire                        clr_i,
  input  wire                        w1c_i,
  input  wire [`EBALU_IO_ADDR_W-1:0] addr_i,
  input  wire [2:0]                  bit_i,
  input  wire [7:0]                  w1c_mask_i,
  input  wire [`EBALU_IO_ADDR_W-1:0] rd_addr_i,
  output reg  [7:0]                  rd_data_o
);
  reg [7:0] mem_q [0:`EBALU_IO_SPACE-1];
  integer   i;

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (i = 0; i < `EBALU_IO_SPACE; i = i + 1)
        mem_q[i] <= `EBALU_BYTE_ZERO;
      rd_data_o <= `EBALU_BYTE_ZERO;
    end
    else
    begin
      if (set_i)
        mem_q[addr_i[`EBALU_IO_IDX_MSB:0]][bit_i] <= 1'b1;
      else if (clr_i)
        mem_q[addr_i[`EBALU_IO_IDX_MSB:0]][bit_i] <= 1'b0;
      else if (w1c_i)
        mem_q[addr_i[`EBALU_IO_IDX_MSB:0]] <= mem_q[addr_i[`EBALU_IO_IDX_MSB:0]] & ~w1c_mask_i;
      rd_data_o <= mem_q[rd_addr_i[`EBALU_IO_IDX_MSB:0]];
    end
  end
endmodule // ebalu_io_bits

// >>> tb/ebalu_core_sva.sv
`timescale 1ns/10ps
`include "ebalu_consts.vh"
module ebalu_core_chk
(
  input wire       clk_i,
  input wire       rst_n_i,
  input wire       start_i,
  input wire [4:0] op_i,
  input wire [7:0] rd_i,
  input wire [7:0] rr_i,
  input wire [7:0] imm_i,
  input wire [5:0] io_addr_i,
  input wire [7:0] result_o,
  input wire       wr_low_o,
  input wire       wr_high_o,
  input wire [5:0] flags_o,
  input wire       busy_o,
  input wire       io_reject_o
);
  reg  word_q;
  wire take = start_i && !word_q;

  // Mirrors the refused second word cycle, so a start there is not taken.
  always @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      word_q <= 1'b0;
    else
      word_q <= take && (op_i == `EBALU_OP_WADD || op_i == `EBALU_OP_WSUB);

  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_add;
    take && op_i == `EBALU_OP_ADD |=> wr_low_o && result_o == $past(rd_i + rr_i);
  endproperty
  a_add: assert property (p_add) else $error("add result wrong");
  property p_sub;
    take && op_i == `EBALU_OP_SUB |=> !busy_o && result_o == $past(rd_i - rr_i);
  endproperty
  a_sub: assert property (p_sub) else $error("subtract result wrong");
  property p_subbk;
    take && op_i == `EBALU_OP_SUBBK && !$past(start_i)
      |=> result_o == $past(rd_i - imm_i - flags_o[`EBALU_F_C]);
  endproperty
  a_subbk: assert property (p_subbk) else $error("borrow subtract wrong");
  property p_and;
    take && op_i == `EBALU_OP_AND && !$past(start_i) |=> result_o == $past(rd_i & rr_i)
      && $stable(flags_o[`EBALU_F_C]) && $stable(flags_o[`EBALU_F_H])
      && $stable(flags_o[`EBALU_F_S]);
  endproperty
  a_and: assert property (p_and) else $error("conjunction wrong");
  property p_xor;
    take && op_i == `EBALU_OP_XOR |=> result_o == $past(rd_i ^ rr_i)
      && !flags_o[`EBALU_F_V] && flags_o[`EBALU_F_N] == result_o[7];
  endproperty
  a_xor: assert property (p_xor) else $error("exclusive disjunction wrong");
  property p_com;
    take && op_i == `EBALU_OP_COM |=> result_o == ~$past(rd_i) && flags_o[`EBALU_F_C];
  endproperty
  a_com: assert property (p_com) else $error("complement wrong");
  property p_wadd;
    take && op_i == `EBALU_OP_WADD |=> busy_o && wr_low_o
      && result_o == $past(rd_i + imm_i) ##1 wr_high_o && !wr_low_o && !busy_o;
  endproperty
  a_wadd: assert property (p_wadd) else $error("word add timing wrong");
  property p_rej;
    take && (op_i == `EBALU_OP_IOSET || op_i == `EBALU_OP_IOCLR)
      |=> io_reject_o == $past(io_addr_i > 6'h1f);
  endproperty
  a_rej: assert property (p_rej) else $error("io address check wrong");
endmodule // ebalu_core_chk

bind ebalu_core ebalu_core_chk u_chk
(
  .clk_i, .rst_n_i, .start_i, .op_i, .rd_i, .rr_i, .imm_i, .io_addr_i,
  .result_o, .wr_low_o, .wr_high_o, .flags_o, .busy_o, .io_reject_o
);

// >>> tb/ebalu_pair_model.sv
`timescale 1ns/10ps
// Register pair as the register file holds it after write-back.
module ebalu_pair_model
(
  input  wire        clk_i,
  input  wire        wr_low_i,
  input  wire        wr_high_i,
  input  wire [7:0]  data_i,
  output reg  [15:0] pair_o
);
  always @(posedge clk_i)
  begin
    if (wr_low_i)
      pair_o[7:0] <= data_i;
    if (wr_high_i)
      pair_o[15:8] <= data_i;
  end
endmodule // ebalu_pair_model

// >>> tb/test_eight_bit_arith_logic_unit.sv
`timescale 1ns/10ps
module test_eight_bit_arith_logic_unit;
  typedef struct packed {logic [7:0] op, a, b, h; logic [15:0] r; logic [7:0] f;} ebalu_row_t;
  reg         clk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg         start_i = 1'b0;
  reg         io_w1c_i = 1'b0;
  reg         w;
  reg  [4:0]  op_i = 5'h00;
  reg  [7:0]  rd_i = 8'h00, rr_i = 8'h00, rd_high_i = 8'h00, imm_i = 8'h00;
  reg  [7:0]  io_w1c_mask_i = 8'h00, m;
  reg  [5:0]  io_addr_i = 6'h00, io_rd_addr_i = 6'h1f;
  reg  [2:0]  io_bit_i = 3'h0;
  wire [7:0]  result_o, io_rd_data_o;
  wire [5:0]  flags_o;
  wire        wr_low_o, wr_high_o, busy_o, skip_o, skip_valid_o, io_reject_o;
  wire [15:0] pair;
  integer     err_total = 0, comparisons = 0, i;
  ebalu_row_t rows [17] = '{
    56'h01_88_88_00_0010_29, 56'h02_0f_70_00_0080_2c, 56'h04_10_01_00_000f_20,
    56'h05_00_01_00_00ff_25, 56'h07_05_03_00_0001_00, 56'h06_80_00_00_0080_04,
    56'h0f_01_00_00_00ff_25, 56'h09_f0_0f_00_0000_23, 56'h0a_c3_81_00_0081_25,
    56'h0b_50_0a_00_005a_21, 56'h0c_00_00_00_0000_23, 56'h0d_3c_ff_00_00c3_25,
    56'h0e_ff_00_00_0000_23, 56'h03_ff_01_7f_8000_0c, 56'h03_c1_3f_ff_0000_03,
    56'h08_00_01_80_7fff_18, 56'h08_05_06_00_ffff_15};

  ebalu_core uut
  (
    .clk_i, .rst_n_i, .start_i, .op_i, .rd_i, .rr_i, .rd_high_i, .imm_i, .io_addr_i,
    .io_bit_i, .io_w1c_i, .io_w1c_mask_i, .io_rd_addr_i, .result_o, .wr_low_o,
    .wr_high_o, .flags_o, .busy_o, .skip_o, .skip_valid_o, .io_reject_o, .io_rd_data_o
  );
  ebalu_pair_model model
  (
    .clk_i, .wr_low_i(wr_low_o), .wr_high_i(wr_high_o), .data_i(result_o), .pair_o(pair)
  );

  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  task chk(input string n, input logic [15:0] e, s);
  begin
    comparisons = comparisons + 1;
    if (s !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      err_total = err_total + 1;
    end
  end
  endtask

  // Issues one operation at a falling edge; hold keeps start high for a follow-on.
  task run(input logic [7:0] o, a, b, input logic hold);
  begin
    op_i = o[4:0];
    rd_i = a;
    rr_i = b;
    imm_i = b;
    start_i = 1'b1;
    @(negedge clk_i) if (!hold) start_i = 1'b0;
  end
  endtask

  task final_report;
  begin
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  initial
  begin
    repeat (1000) @(posedge clk_i);
    err_total = err_total + 1;
    final_report;
  end

  initial
  begin
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    for (i = 0; i < 17; i = i + 1)
    begin
      rd_high_i = rows[i].h;
      w = rows[i].op == 8'h03 || rows[i].op == 8'h08;
      m = w ? 8'h1f : 8'h2f;
      run(rows[i].op, rows[i].a, rows[i].b, 1'b0);
      chk("busy", {15'h0, w}, busy_o);
      repeat (w ? 2 : 1) @(negedge clk_i);
      chk("flags", rows[i].f & m, flags_o & m);
      chk("pair", w ? rows[i].r : rows[i].r[7:0], w ? pair : pair[7:0]);
    end
    run(8'h01, 8'h01, 8'h02, 1'b1);
    chk("result", 16'h03, result_o);
    run(8'h04, 8'h05, 8'h03, 1'b1);
    chk("result", 16'h02, result_o);
    rd_high_i = 8'h00;
    run(8'h03, 8'hff, 8'h01, 1'b1);
    run(8'h01, 8'h01, 8'h02, 1'b1);
    chk("word", 16'h201, {wr_high_o, wr_low_o, result_o});
    io_addr_i = 6'h1f;
    io_bit_i = 3'h7;
    run(8'h10, 8'h00, 8'h00, 1'b1);
    chk("reject", 16'h0, io_reject_o);
    io_bit_i = 3'h0;
    run(8'h10, 8'h00, 8'h00, 1'b0);
    repeat (2) @(negedge clk_i);
    chk("io", 16'h81, io_rd_data_o);
    io_w1c_mask_i = 8'h80;
    io_w1c_i = 1'b1;
    @(negedge clk_i) io_w1c_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("w1c", 16'h01, io_rd_data_o);
    run(8'h12, 8'h00, 8'h00, 1'b1);
    chk("skip", 16'h3, {skip_valid_o, skip_o});
    run(8'h13, 8'h00, 8'h00, 1'b1);
    chk("skip", 16'h2, {skip_valid_o, skip_o});
    run(8'h11, 8'h00, 8'h00, 1'b0);
    repeat (2) @(negedge clk_i);
    chk("io", 16'h00, io_rd_data_o);
    io_addr_i = 6'h20;
    run(8'h10, 8'h00, 8'h00, 1'b0);
    chk("reject", 16'h1, io_reject_o);
    io_rd_addr_i = 6'h00;
    repeat (2) @(negedge clk_i);
    chk("io", 16'h00, io_rd_data_o);
    rst_n_i = 1'b0;
    @(negedge clk_i);
    chk("reset", 16'h0, {flags_o, result_o});
    rst_n_i = 1'b1;
    run(8'h01, 8'h7f, 8'h01, 1'b0);
    chk("result", 16'h80, result_o);
    chk("flags", 16'h2c, flags_o & 8'h2f);
    final_report;
  end
endmodule // test_eight_bit_arith_logic_unit
